// ---- design/aeq_dwell_timer.sv ----
// Dwell timer for the equalizer search.
// Assumes one clock; counts clock cycles and flags half and full dwell.
`timescale 1ns/10ps
module aeq_dwell_timer
  import aeq_pkg::*;
#(
  parameter int BASE_CYCLES = AEQ_DWELL_BASE_CYCLES
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // Control
  input  wire logic       start,
  input  wire logic [1:0] scale,
  // Status
  output logic            half_done,
  output logic            full_done
);

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  logic [19:0] count;
  logic [19:0] next_count;
  logic [19:0] span;

  always_comb begin
    span = 20'(BASE_CYCLES) << scale;
    next_count = start ? 20'h00001 : count + 20'h00001;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count <= 20'h00000;
    end else begin
      count <= next_count;
    end
  end

  // Compare with >= so a shorter dwell written mid-count still ends the wait,
  // instead of stalling the search until the counter wraps.
  assign half_done = (count >= (span >> 1));
  assign full_done = (count >= span);

endmodule

// ---- design/aeq_err_counter.sv ----
// Error accumulator used to score one equalizer setting.
// Assumes error strobes are already in the clock domain.
`timescale 1ns/10ps
module aeq_err_counter
  import aeq_pkg::*;
#(
  parameter int W = AEQ_ERR_CNT_W
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         reset,
  // Control
  input  wire logic         clear,
  input  wire logic         enable,
  input  wire logic         err_hit,
  // Result
  output logic [W-1:0]      count
);

  logic [W-1:0] next_count;

  // Saturates so a noisy setting cannot wrap back to a small score.
  always_comb begin
    next_count = count;
    if (clear) begin
      next_count = '0;
    end else if (enable && err_hit && (count != {W{1'b1}})) begin
      next_count = count + W'(1);
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule

// ---- design/aeq_pkg.sv ----
// Package for the adaptive equalizer search controller.
// Assumes a single 10 MHz clock domain and a byte-wide register port.
package aeq_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] AEQ_OFF_ERR_SEL  = 8'h42;
  localparam logic [7:0] AEQ_OFF_CTRL     = 8'hD2;
  localparam logic [7:0] AEQ_OFF_STATUS   = 8'hD3;
  localparam logic [7:0] AEQ_OFF_LIMITS   = 8'hD5;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int AEQ_CTRL_RESTART_BIT   = 3;
  localparam int AEQ_CTRL_FLOOR_EN_BIT  = 2;
  localparam int AEQ_CTRL_AUTO_DIS_BIT  = 7;
  localparam int AEQ_CTRL_DWELL_LSB     = 0;
  localparam int AEQ_ERRSEL_CDR_BIT     = 0;
  localparam int AEQ_ERRSEL_ENC_BIT     = 1;
  localparam int AEQ_ERRSEL_PAR_BIT     = 2;
  localparam int AEQ_ERRSEL_THR_LSB     = 4;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] AEQ_RST_ERR_SEL  = 8'h27;
  localparam logic [7:0] AEQ_RST_CTRL     = 8'h00;
  localparam logic [7:0] AEQ_RST_LIMITS   = 8'hF0;

  // ----------------------------------------------------------------------
  // Timing and counter width
  // ----------------------------------------------------------------------
  localparam int AEQ_DWELL_BASE_CYCLES  = 65536;
  localparam int AEQ_ERR_CNT_W          = 8;

  typedef struct packed {
    logic cdr_err;
    logic enc_err;
    logic par_err;
  } aeq_err_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } aeq_reg_req_t;

endpackage

// ---- design/aeq_search_ctrl.sv ----
// Adaptive equalizer search controller for one receive port.
// Assumes a byte register port from the local control logic and
// lock and error inputs from the receiver, the receiver pins asynchronous to clock.
`timescale 1ns/10ps
module aeq_search_ctrl
  import aeq_pkg::*;
#(
  parameter int DWELL_CYCLES = AEQ_DWELL_BASE_CYCLES
) (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          reset,
  input  wire logic          digital_logic_reset,
  // Register port
  input  wire aeq_reg_req_t  reg_req,
  output logic [7:0]         reg_rdata,
  // Receiver status pins
  input  wire logic          cdr_lock_pin,
  input  wire logic          compat_ser_pin,
  input  wire aeq_err_t      err_pin,
  // Equalizer drive
  output logic [3:0]         eq_gain,
  output logic               eq_locked
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [4:0] sync1;
  logic [4:0] sync2;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
    end else begin
      sync1 <= {cdr_lock_pin, compat_ser_pin, err_pin};
      sync2 <= sync1;
    end
  end

  logic     lock_s;
  logic     compat_s;
  aeq_err_t err_s;
  assign lock_s   = sync2[4];
  assign compat_s = sync2[3];
  assign err_s    = aeq_err_t'(sync2[2:0]);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0] err_sel;
  logic [7:0] ctrl;
  logic [7:0] limits;
  logic [7:0] next_err_sel;
  logic [7:0] next_ctrl;
  logic [7:0] next_limits;
  logic       restart_req;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  always_comb begin
    next_err_sel = err_sel;
    next_ctrl    = ctrl;
    next_limits  = limits;
    restart_req  = 1'b0;
    if (reg_req.wr) begin
      if (hit(reg_req.addr, AEQ_OFF_ERR_SEL)) begin
        next_err_sel = reg_req.wdata;
      end
      if (hit(reg_req.addr, AEQ_OFF_CTRL)) begin
        next_ctrl = reg_req.wdata;
        next_ctrl[AEQ_CTRL_RESTART_BIT] = 1'b0;
        restart_req = reg_req.wdata[AEQ_CTRL_RESTART_BIT];
      end
      if (hit(reg_req.addr, AEQ_OFF_LIMITS)) begin
        next_limits = reg_req.wdata;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      err_sel <= AEQ_RST_ERR_SEL;
      ctrl    <= AEQ_RST_CTRL;
      limits  <= AEQ_RST_LIMITS;
    end else begin
      err_sel <= next_err_sel;
      ctrl    <= next_ctrl;
      limits  <= next_limits;
    end
  end

  logic [3:0] ceiling;
  logic [3:0] floor_val;
  logic [3:0] min_gain;
  logic       floor_en;
  logic [3:0] threshold;
  logic [1:0] dwell_sel;
  logic       auto_off;

  assign ceiling   = limits[7:4];
  assign floor_val = limits[3:0];
  assign floor_en  = ctrl[AEQ_CTRL_FLOOR_EN_BIT];
  assign min_gain  = floor_en ? floor_val : 4'h0;
  assign threshold = err_sel[AEQ_ERRSEL_THR_LSB +: 4];
  assign dwell_sel = ctrl[AEQ_CTRL_DWELL_LSB +: 2];
  assign auto_off  = ctrl[AEQ_CTRL_AUTO_DIS_BIT];

  // ----------------------------------------------------------------------
  // Dwell timer and error scoring
  // ----------------------------------------------------------------------
  logic       tmr_start;
  logic       half_done;
  logic       full_done;
  logic [7:0] err_count;
  logic       err_hit;
  logic       err_window;
  logic       next_err_window;

  aeq_dwell_timer #(
    .BASE_CYCLES (DWELL_CYCLES)
  ) u_timer (
    .clock     (clock),
    .reset     (reset),
    .start     (tmr_start),
    .scale     (dwell_sel),
    .half_done (half_done),
    .full_done (full_done)
  );

  assign err_hit = (err_s.cdr_err & err_sel[AEQ_ERRSEL_CDR_BIT])
                 | (err_s.enc_err & err_sel[AEQ_ERRSEL_ENC_BIT])
                 | (err_s.par_err & err_sel[AEQ_ERRSEL_PAR_BIT]);

  aeq_err_counter #(
    .W (8)
  ) u_errs (
    .clock   (clock),
    .reset   (reset),
    .clear   (tmr_start),
    .enable  (err_window),
    .err_hit (err_hit),
    .count   (err_count)
  );

  // Counting stops at half dwell so the first half scores the setting.
  always_comb begin
    next_err_window = err_window;
    if (tmr_start) begin
      next_err_window = 1'b1;
    end else if (half_done) begin
      next_err_window = 1'b0;
    end
  end

  logic too_many_errs;
  assign too_many_errs = (err_count > {4'h0, threshold});

  // ----------------------------------------------------------------------
  // Search state machine
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_DWELL = 3'b001,
    ST_HOLD  = 3'b010,
    ST_START = 3'b100
  } aeq_state_t;

  aeq_state_t state;
  aeq_state_t next_state;
  logic [3:0] gain;
  logic [3:0] next_gain;
  logic       auto_done;
  logic       next_auto_done;
  logic       lock_good;

  assign lock_good = lock_s && !too_many_errs;

  function automatic logic [3:0] step_gain(input logic [3:0] g, input logic [3:0] hi,
                                           input logic [3:0] lo);
    step_gain = (g >= hi) ? lo : g + 4'h1;
  endfunction

  always_comb begin
    next_state     = state;
    next_gain      = gain;
    next_auto_done = auto_done;
    tmr_start      = 1'b0;
    case (state)
      ST_START: begin
        next_gain  = min_gain;
        tmr_start  = 1'b1;
        next_state = ST_DWELL;
      end
      ST_DWELL: begin
        if (full_done) begin
          if (lock_good) begin
            if (!auto_done && compat_s && !auto_off) begin
              next_auto_done = 1'b1;
              next_state     = ST_START;
            end else begin
              next_state = ST_HOLD;
            end
          end else begin
            next_gain = step_gain(gain, ceiling, min_gain);
            tmr_start = 1'b1;
          end
        end
      end
      ST_HOLD: begin
        if (!lock_s) begin
          next_gain  = step_gain(gain, ceiling, min_gain);
          tmr_start  = 1'b1;
          next_state = ST_DWELL;
        end
      end
      default: begin
        next_state = ST_START;
      end
    endcase
    if (restart_req || digital_logic_reset) begin
      next_state = ST_START;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state      <= ST_START;
      gain       <= 4'h0;
      auto_done  <= 1'b0;
      err_window <= 1'b0;
    end else begin
      state      <= next_state;
      gain       <= next_gain;
      auto_done  <= next_auto_done;
      err_window <= next_err_window;
    end
  end

  assign eq_gain   = gain;
  assign eq_locked = (state == ST_HOLD);

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = 8'h00;
    if (hit(reg_req.addr, AEQ_OFF_ERR_SEL)) begin
      next_rdata = err_sel;
    end else if (hit(reg_req.addr, AEQ_OFF_CTRL)) begin
      next_rdata = ctrl;
    end else if (hit(reg_req.addr, AEQ_OFF_STATUS)) begin
      next_rdata = {eq_locked, 3'h0, gain};
    end else if (hit(reg_req.addr, AEQ_OFF_LIMITS)) begin
      next_rdata = limits;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_gain_ceiling: assert property (@(posedge clock) disable iff (reset)
    (state == ST_DWELL && gain <= ceiling && !reg_req.wr) |=> (gain <= ceiling))
    else $error("Gain went above the ceiling.");

  a_hold_frozen: assert property (@(posedge clock) disable iff (reset)
    (state == ST_HOLD && lock_s && !restart_req && !digital_logic_reset)
      |=> (gain == $past(gain)))
    else $error("Gain changed while locked.");

  // Restart takes two steps: the start state, then the minimum gain loaded.
  sequence s_restart_load;
    ##1 (state == ST_START) ##1 (gain == $past(min_gain));
  endsequence

  a_restart_min: assert property (@(posedge clock) disable iff (reset)
    restart_req |-> s_restart_load)
    else $error("Restart did not load minimum gain.");

  a_loss_advance: assert property (@(posedge clock) disable iff (reset)
    (state == ST_HOLD && !lock_s && !restart_req && !digital_logic_reset)
      |=> (state == ST_DWELL))
    else $error("Lock loss did not resume search.");

  a_floor_zero: assert property (@(posedge clock) disable iff (reset)
    (state == ST_START && !floor_en) |=> (gain == 4'h0))
    else $error("Search start not zero with floor off.");

  a_window_half: assert property (@(posedge clock) disable iff (reset)
    (half_done && !tmr_start) |=> !err_window)
    else $error("Error window open past half dwell.");

  a_dwell_step: assert property (@(posedge clock) disable iff (reset)
    (state == ST_DWELL && !full_done && !restart_req && !digital_logic_reset)
      |=> (gain == $past(gain)))
    else $error("Gain moved before dwell ended.");

  a_status_read: assert property (@(posedge clock) disable iff (reset)
    (reg_req.rd && reg_req.addr == AEQ_OFF_STATUS) |=> (reg_rdata[3:0] == $past(gain)))
    else $error("Status read did not show gain.");

endmodule

// ---- verif/aeq_search_ctrl_tb.sv ----
// Self-checking bench for the equalizer search controller.
// Assumes the serializer model on the pins and a 16-cycle dwell base.
`timescale 1ns/10ps
module aeq_search_ctrl_tb;
  import aeq_pkg::*;
  localparam int D = 16;
  typedef struct packed {logic wr; logic [7:0] addr; logic [7:0] data;} aeq_tb_row_t;

  logic         clock, reset, dlr, locked, compat, lock_pin, compat_pin;
  aeq_reg_req_t req;
  logic [7:0]   rdata, rd;
  logic [3:0]   gain, good, dly, lo, hi;
  aeq_err_t     err_pins, mask;
  int           err_total, n_checks, gap, wraps, seen_lock, been, back;

  aeq_tb_row_t rows [12] = '{
    '{1'b0, 8'h42, 8'h27}, '{1'b0, 8'hD2, 8'h00}, '{1'b0, 8'hD5, 8'hF0},
    '{1'b1, 8'h10, 8'h5A}, '{1'b0, 8'h10, 8'h00},
    '{1'b1, 8'hD2, 8'h0C}, '{1'b0, 8'hD2, 8'h04},
    '{1'b1, 8'h42, 8'hA5}, '{1'b0, 8'h42, 8'hA5},
    '{1'b1, 8'h42, 8'h27}, '{1'b1, 8'hD2, 8'h00}, '{1'b1, 8'hD5, 8'h30}};

  aeq_search_ctrl #(.DWELL_CYCLES(D)) aeq_search_ctrl_inst (.clock(clock), .reset(reset),
    .digital_logic_reset(dlr), .reg_req(req), .reg_rdata(rdata), .cdr_lock_pin(lock_pin),
    .compat_ser_pin(compat_pin), .err_pin(err_pins), .eq_gain(gain), .eq_locked(locked));
  aeq_serializer_model aeq_serializer_model_inst (.clock(clock), .reset(reset),
    .eq_gain(gain), .good_gain(good), .lock_delay(dly), .err_mask(mask),
    .compatible(compat), .cdr_lock_pin(lock_pin), .compat_ser_pin(compat_pin),
    .err_pin(err_pins));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic timeout(input string what);
    err_total++;
    $display("[FAIL] wait for %s expected done seen timeout", what);
    complete_run();
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    req <= '0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    req <= '0;
    tick(1);
    d = rdata;
  endtask
  task automatic set_link(input logic [3:0] g, input logic [3:0] dl, input aeq_err_t m);
    @(posedge clock);
    good <= g;
    dly  <= dl;
    mask <= m;
  endtask
  task automatic do_reset();
    @(posedge clock);
    reset <= 1'b1;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
  endtask
  task automatic wait_lock(input int n);
    for (int i = 0; i < n && locked !== 1'b1; i++) tick(1);
    if (locked !== 1'b1) timeout("lock");
  endtask
  task automatic wait_gain(input logic [3:0] g);
    for (int i = 0; i < 400 && gain !== g; i++) tick(1);
    if (gain !== g) timeout("gain");
  endtask
  task automatic watch(input int n);
    logic [3:0] prev;
    int         since;
    tick(1);
    prev = gain;
    lo = gain;
    hi = gain;
    wraps = 0;
    gap = 0;
    since = 0;
    seen_lock = 0;
    repeat (n) begin
      tick(1);
      since++;
      if (locked === 1'b1) seen_lock = 1;
      if (gain < lo) lo = gain;
      if (gain > hi) hi = gain;
      if (gain !== prev) begin
        if (gain < prev) wraps++;
        gap = since;
        since = 0;
        prev = gain;
      end
    end
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    reset = 1'b1;
    dlr = 1'b0;
    compat = 1'b0;
    req = '0;
    good = 4'hF;
    dly = 4'h0;
    mask = '0;
    err_total = 0;
    n_checks = 0;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wr) reg_wr(rows[i].addr, rows[i].data);
      else begin
        reg_rd(rows[i].addr, rd);
        check("register", rows[i].data, rd);
      end
    end
    $display("Test registers done");
    watch(200);
    check("ceiling", 8'h03, {4'h0, hi});
    check("wrap", 8'h01, {7'h0, wraps > 0 && lo == 0});
    check("dwell x1", 8'h01, {7'h0, gap >= D && gap <= D + 2});
    reg_wr(8'hD2, 8'h03);
    watch(600);
    check("dwell x8", 8'h01, {7'h0, gap >= 8 * D && gap <= 8 * D + 2});
    reg_wr(8'hD2, 8'h00);
    $display("Test search done");
    set_link(4'h2, 4'h5, '0);
    wait_lock(200);
    check("lock gain", 8'h02, {4'h0, gain});
    watch(100);
    check("held gain", 8'h22, {lo, hi});
    reg_rd(8'hD3, rd);
    check("status", 8'h82, rd);
    reg_wr(8'hD3, 8'h00);
    reg_rd(8'hD3, rd);
    check("status ro", 8'h82, rd);
    set_link(4'h3, 4'h5, '0);
    tick(4);
    wait_lock(40);
    check("relock gain", 8'h03, {4'h0, gain});
    $display("Test lock done");
    for (int k = 0; k < 3; k++) begin
      reg_wr(8'h42, 8'h20 | (8'h01 << k));
      set_link(4'h3, 4'h0, aeq_err_t'(3'b100 >> k));
      reg_wr(8'hD2, 8'h08);
      watch(120);
      check("noisy lock", 8'h00, 8'(seen_lock));
      set_link(4'h3, 4'h0, aeq_err_t'(~(3'b100 >> k)));
      wait_lock(120);
      check("quiet lock", 8'h03, {4'h0, gain});
    end
    reg_wr(8'h42, 8'h27);
    set_link(4'hF, 4'h0, '0);
    $display("Test errors done");
    wait_gain(4'h2);
    reg_wr(8'hD2, 8'h08);
    tick(3);
    check("restart gain", 8'h00, {4'h0, gain});
    wait_gain(4'h2);
    @(posedge clock);
    dlr <= 1'b1;
    repeat (3) @(posedge clock);
    dlr <= 1'b0;
    tick(3);
    check("logic reset gain", 8'h00, {4'h0, gain});
    reg_wr(8'hD5, 8'h82);
    wait_gain(4'h4);
    reg_wr(8'hD2, 8'h0C);
    tick(3);
    check("floor restart", 8'h02, {4'h0, gain});
    watch(200);
    check("floor range", 8'h28, {lo, hi});
    check("floor wrap", 8'h01, {7'h0, wraps > 0});
    $display("Test restart done");
    @(posedge clock);
    compat <= 1'b1;
    set_link(4'h2, 4'h0, '0);
    do_reset();
    been = 0;
    back = 0;
    for (int i = 0; i < 600 && locked !== 1'b1; i++) begin
      tick(1);
      if (gain === 4'h2) been = 1;
      if (been && gain === 4'h0) back = 1;
    end
    if (locked !== 1'b1) timeout("auto lock");
    check("auto restart", 8'h01, 8'(back));
    check("auto gain", 8'h02, {4'h0, gain});
    $display("Test auto restart done");
    complete_run();
  end
endmodule

// ---- verif/aeq_serializer_model.sv ----
// Behavioural model of the remote serializer as the receiver sees it.
// Assumes the bench picks the clean gain, the lock delay and the error kinds.
`timescale 1ns/10ps
module aeq_serializer_model
  import aeq_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // Equalizer setting on the link
  input  wire logic [3:0] eq_gain,
  // Bench control
  input  wire logic [3:0] good_gain,
  input  wire logic [3:0] lock_delay,
  input  wire aeq_err_t   err_mask,
  input  wire logic       compatible,
  // Receiver status pins
  output logic            cdr_lock_pin,
  output logic            compat_ser_pin,
  output aeq_err_t        err_pin
);
  logic [3:0] settle;

  // A slow link locks only after the gain has rested on the clean value for
  // a while, so the dwell check is exercised rather than an instant answer.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      settle <= 4'h0;
    end else if (eq_gain != good_gain) begin
      settle <= 4'h0;
    end else if (settle != 4'hF) begin
      settle <= settle + 4'h1;
    end
  end

  assign cdr_lock_pin   = (eq_gain == good_gain) && (settle >= lock_delay);
  assign compat_ser_pin = compatible;
  assign err_pin        = err_mask;
endmodule
